// ===== verilog/jemc_pkg.sv
// Purpose: Shared constants and types for the test-access and emulation pin block
// Assumes: Two emulation pins, four-bit instruction register
// Notes: Emulation pin vectors are ordered {pin one, pin zero}
package jemc_pkg;

	// ==========================================================
	// Instruction register
	localparam int IR_WIDTH = 4;
	localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hF;
	localparam logic [IR_WIDTH-1:0] IR_EMU_DIR = 4'h2;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;

	// ==========================================================
	// Emulation pin patterns and reset values
	localparam int EMU_PINS = 2;
	localparam logic [EMU_PINS-1:0] DIR_RESET = 2'h0;
	localparam logic [EMU_PINS-1:0] EMU_IDLE = 2'h3;
	localparam logic [EMU_PINS-1:0] BSC_PATTERN = 2'h1;
	localparam logic [EMU_PINS-1:0] WIR_PATTERN = 2'h2;
	localparam logic [EMU_PINS-1:0] OE_N_OFF = 2'h3;
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h3,
		TAP_CAP_DR = 4'h2,
		TAP_SHIFT_DR = 4'h6,
		TAP_EXIT1_DR = 4'h7,
		TAP_PAUSE_DR = 4'h5,
		TAP_EXIT2_DR = 4'h4,
		TAP_UPD_DR = 4'hC,
		TAP_SEL_IR = 4'hD,
		TAP_CAP_IR = 4'hF,
		TAP_SHIFT_IR = 4'hE,
		TAP_EXIT1_IR = 4'hA,
		TAP_PAUSE_IR = 4'hB,
		TAP_EXIT2_IR = 4'h9,
		TAP_UPD_IR = 4'h8
	} jemc_tap_state_t;

	typedef struct packed {
		logic [EMU_PINS-1:0] level;
		logic [EMU_PINS-1:0] oe_n;
	} jemc_emu_drive_t;

endpackage : jemc_pkg

// ===== verilog/jemc_top.sv
// Purpose: Test access port, emulation event pins and debug mode straps
// Assumes: test_clock may stop whenever test_reset is low
// Notes: Mode outputs and pin drivers live on clock; the scan chain lives on test_clock
`timescale 1ns/100ps

// What this block does
// R1: Test reset high hands control to scan
// R2: Test reset low keeps functional mode
// R3: Probe holds test reset low normally
// R4: Mode select sampled on rising test clock
// R5: Data in shifted on rising test clock
// R6: Data out changes on falling test clock
// R7: Emulation pins are scan-configured event lines
// R8: Test reset rise with 01 latches boundary-scan
// R9: Reset release with 10 enters wait-in-reset
// R10: Probe changes inputs on falling test clock
module jemc_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic test_clock,
	input wire logic test_reset,
	input wire logic test_mode_select,
	input wire logic test_data_in,
	output logic test_data_out,
	input wire logic [jemc_pkg::EMU_PINS-1:0] emu_pin_in,
	output jemc_pkg::jemc_emu_drive_t emu_drive,
	input wire logic [jemc_pkg::EMU_PINS-1:0] device_event,
	output logic [jemc_pkg::EMU_PINS-1:0] probe_event,
	output logic scan_control,
	output logic boundary_scan_mode,
	output logic wait_in_reset_mode
);

	// ==========================================================
	// Test clock domain: TAP controller
	jemc_pkg::jemc_tap_state_t tap_state_reg, tap_state_next;
	logic [jemc_pkg::IR_WIDTH-1:0] ir_shift_reg, ir_reg;
	logic [jemc_pkg::EMU_PINS-1:0] dir_shift_reg, dir_reg;
	logic bypass_reg;
	logic tdo_reg;
	wire tms = test_mode_select;
	wire sel_dir = (ir_reg == jemc_pkg::IR_EMU_DIR);
	wire dr_out = sel_dir ? dir_shift_reg[0] : bypass_reg;
	wire shift_bit = (tap_state_reg == jemc_pkg::TAP_SHIFT_IR) ? ir_shift_reg[0] : dr_out;
	wire shifting = (tap_state_reg == jemc_pkg::TAP_SHIFT_IR) || (tap_state_reg == jemc_pkg::TAP_SHIFT_DR);

	always_comb begin
		unique case (tap_state_reg)
			jemc_pkg::TAP_RESET: tap_state_next = tms ? jemc_pkg::TAP_RESET : jemc_pkg::TAP_IDLE;
			jemc_pkg::TAP_IDLE: tap_state_next = tms ? jemc_pkg::TAP_SEL_DR : jemc_pkg::TAP_IDLE;
			jemc_pkg::TAP_SEL_DR: tap_state_next = tms ? jemc_pkg::TAP_SEL_IR : jemc_pkg::TAP_CAP_DR;
			jemc_pkg::TAP_CAP_DR: tap_state_next = tms ? jemc_pkg::TAP_EXIT1_DR : jemc_pkg::TAP_SHIFT_DR;
			jemc_pkg::TAP_SHIFT_DR: tap_state_next = tms ? jemc_pkg::TAP_EXIT1_DR : jemc_pkg::TAP_SHIFT_DR;
			jemc_pkg::TAP_EXIT1_DR: tap_state_next = tms ? jemc_pkg::TAP_UPD_DR : jemc_pkg::TAP_PAUSE_DR;
			jemc_pkg::TAP_PAUSE_DR: tap_state_next = tms ? jemc_pkg::TAP_EXIT2_DR : jemc_pkg::TAP_PAUSE_DR;
			jemc_pkg::TAP_EXIT2_DR: tap_state_next = tms ? jemc_pkg::TAP_UPD_DR : jemc_pkg::TAP_SHIFT_DR;
			jemc_pkg::TAP_UPD_DR: tap_state_next = tms ? jemc_pkg::TAP_SEL_DR : jemc_pkg::TAP_IDLE;
			jemc_pkg::TAP_SEL_IR: tap_state_next = tms ? jemc_pkg::TAP_RESET : jemc_pkg::TAP_CAP_IR;
			jemc_pkg::TAP_CAP_IR: tap_state_next = tms ? jemc_pkg::TAP_EXIT1_IR : jemc_pkg::TAP_SHIFT_IR;
			jemc_pkg::TAP_SHIFT_IR: tap_state_next = tms ? jemc_pkg::TAP_EXIT1_IR : jemc_pkg::TAP_SHIFT_IR;
			jemc_pkg::TAP_EXIT1_IR: tap_state_next = tms ? jemc_pkg::TAP_UPD_IR : jemc_pkg::TAP_PAUSE_IR;
			jemc_pkg::TAP_PAUSE_IR: tap_state_next = tms ? jemc_pkg::TAP_EXIT2_IR : jemc_pkg::TAP_PAUSE_IR;
			jemc_pkg::TAP_EXIT2_IR: tap_state_next = tms ? jemc_pkg::TAP_UPD_IR : jemc_pkg::TAP_SHIFT_IR;
			jemc_pkg::TAP_UPD_IR: tap_state_next = tms ? jemc_pkg::TAP_SEL_DR : jemc_pkg::TAP_IDLE;
		endcase
	end

	// Test reset low holds the whole scan side idle, so pins are ignored
	always_ff @(posedge test_clock or negedge test_reset) begin // [R2]
		if (!test_reset) begin
			tap_state_reg <= jemc_pkg::TAP_RESET;
		end else begin
			tap_state_reg <= tap_state_next; // [R4]
		end
	end

	always_ff @(posedge test_clock or negedge test_reset) begin
		if (!test_reset) begin
			ir_shift_reg <= jemc_pkg::IR_CAPTURE;
			ir_reg <= jemc_pkg::IR_BYPASS;
		end else if (tap_state_reg == jemc_pkg::TAP_RESET) begin
			ir_reg <= jemc_pkg::IR_BYPASS;
		end else if (tap_state_reg == jemc_pkg::TAP_CAP_IR) begin
			ir_shift_reg <= jemc_pkg::IR_CAPTURE;
		end else if (tap_state_reg == jemc_pkg::TAP_SHIFT_IR) begin
			ir_shift_reg <= {test_data_in, ir_shift_reg[jemc_pkg::IR_WIDTH-1:1]}; // [R5]
		end else if (tap_state_reg == jemc_pkg::TAP_UPD_IR) begin
			ir_reg <= ir_shift_reg;
		end
	end

	always_ff @(posedge test_clock or negedge test_reset) begin
		if (!test_reset) begin
			bypass_reg <= 1'b0;
			dir_shift_reg <= jemc_pkg::DIR_RESET;
			dir_reg <= jemc_pkg::DIR_RESET;
		end else if (tap_state_reg == jemc_pkg::TAP_RESET) begin
			dir_reg <= jemc_pkg::DIR_RESET;
		end else if (tap_state_reg == jemc_pkg::TAP_CAP_DR) begin
			bypass_reg <= 1'b0;
			dir_shift_reg <= dir_reg;
		end else if (tap_state_reg == jemc_pkg::TAP_SHIFT_DR) begin
			bypass_reg <= test_data_in; // [R5]
			if (sel_dir) begin
				dir_shift_reg <= {test_data_in, dir_shift_reg[jemc_pkg::EMU_PINS-1:1]}; // [R5]
			end
		end else if (tap_state_reg == jemc_pkg::TAP_UPD_DR && sel_dir) begin
			dir_reg <= dir_shift_reg; // [R7]
		end
	end

	// Falling edge gives the probe half a test clock of setup on data out
	always_ff @(negedge test_clock or negedge test_reset) begin
		if (!test_reset) begin
			tdo_reg <= 1'b0;
		end else if (shifting) begin
			tdo_reg <= shift_bit; // [R6]
		end
	end

	assign test_data_out = tdo_reg;

	// ==========================================================
	// System clock domain: synchronisers
	logic [1:0] trst_sync_reg;
	logic [2*jemc_pkg::EMU_PINS-1:0] dir_sync_reg;
	logic [2*jemc_pkg::EMU_PINS-1:0] emu_sync_reg;
	logic trst_prev_reg;
	wire trst_s = trst_sync_reg[1];
	wire [jemc_pkg::EMU_PINS-1:0] dir_s = dir_sync_reg[2*jemc_pkg::EMU_PINS-1:jemc_pkg::EMU_PINS];
	wire [jemc_pkg::EMU_PINS-1:0] emu_s = emu_sync_reg[2*jemc_pkg::EMU_PINS-1:jemc_pkg::EMU_PINS];
	wire trst_rise = trst_s && !trst_prev_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			trst_sync_reg <= 2'h0;
			dir_sync_reg <= {jemc_pkg::DIR_RESET, jemc_pkg::DIR_RESET};
			emu_sync_reg <= {jemc_pkg::EMU_IDLE, jemc_pkg::EMU_IDLE};
			trst_prev_reg <= 1'b0;
		end else begin
			trst_sync_reg <= {trst_sync_reg[0], test_reset};
			dir_sync_reg <= {dir_sync_reg[jemc_pkg::EMU_PINS-1:0], dir_reg};
			emu_sync_reg <= {emu_sync_reg[jemc_pkg::EMU_PINS-1:0], emu_pin_in};
			trst_prev_reg <= trst_s;
		end
	end

	// ==========================================================
	// System clock domain: modes and emulation pins
	logic scan_control_reg, bsc_mode_reg, wir_mode_reg;
	logic [1:0] strap_wait_reg;
	logic [jemc_pkg::EMU_PINS-1:0] probe_event_reg;
	jemc_pkg::jemc_emu_drive_t emu_drive_reg;
	wire strap_sample = (strap_wait_reg == jemc_pkg::STRAP_WAIT);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scan_control_reg <= 1'b0;
			bsc_mode_reg <= 1'b0;
		end else begin
			scan_control_reg <= trst_s; // [R1] [R2]
			if (!trst_s) begin
				bsc_mode_reg <= 1'b0; // [R2]
			end else if (trst_rise && emu_s == jemc_pkg::BSC_PATTERN) begin
				bsc_mode_reg <= 1'b1; // [R8]
			end
		end
	end

	// Straps are read once the synchroniser holds post-reset pin levels
	// Counter parks at 3, so later event traffic on the pins cannot change the mode
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_wait_reg <= 2'h0;
			wir_mode_reg <= 1'b0;
		end else if (strap_wait_reg != 2'h3) begin
			strap_wait_reg <= strap_wait_reg + 2'h1;
			if (strap_sample) begin
				wir_mode_reg <= (emu_s == jemc_pkg::WIR_PATTERN); // [R9]
			end
		end
	end

	genvar p;
	generate
		for (p = 0; p < jemc_pkg::EMU_PINS; p++) begin : g_emu
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					emu_drive_reg.level[p] <= 1'b0;
					emu_drive_reg.oe_n[p] <= 1'b1;
					probe_event_reg[p] <= 1'b0;
				end else begin
					emu_drive_reg.level[p] <= device_event[p]; // [R7]
					emu_drive_reg.oe_n[p] <= !(trst_s && dir_s[p]); // [R7] [R2]
					probe_event_reg[p] <= trst_s && !dir_s[p] && !emu_s[p]; // [R7]
				end
			end
		end
	endgenerate

	assign emu_drive = emu_drive_reg;
	assign probe_event = probe_event_reg;
	assign scan_control = scan_control_reg;
	assign boundary_scan_mode = bsc_mode_reg;
	assign wait_in_reset_mode = wir_mode_reg;

	// ==========================================================
	// Checks
	chk_scan_owner: assert property (@(posedge clock) disable iff (!arst_n) trst_s |=> scan_control_reg) // [R1]
		else $error("scan control not granted under test reset");
	chk_func_ignore: assert property (@(posedge clock) disable iff (!arst_n) // [R2]
		!trst_s |=> !scan_control_reg && !bsc_mode_reg && emu_drive_reg.oe_n == jemc_pkg::OE_N_OFF)
		else $error("scan side active while test reset low");
	chk_tms_sample: assert property (@(posedge test_clock) disable iff (!test_reset) // [R4]
		(tap_state_reg == jemc_pkg::TAP_IDLE) ##1 (tap_state_reg == jemc_pkg::TAP_SEL_DR) |-> $past(tms))
		else $error("tap left idle without mode select high");
	chk_tdi_shift: assert property (@(posedge test_clock) disable iff (!test_reset) // [R5]
		(tap_state_reg == jemc_pkg::TAP_SHIFT_IR) |=> ir_shift_reg[jemc_pkg::IR_WIDTH-1] == $past(test_data_in))
		else $error("data in not shifted into instruction register");
	chk_tdo_fall: assert property (@(negedge test_clock) disable iff (!test_reset) // [R6]
		(tap_state_reg == jemc_pkg::TAP_SHIFT_IR) |=> tdo_reg == $past(ir_shift_reg[0]))
		else $error("data out wrong after falling edge");
	chk_emu_drive: assert property (@(posedge clock) disable iff (!arst_n) // [R7]
		(trst_s && dir_s[0]) |=> !emu_drive_reg.oe_n[0] && emu_drive_reg.level[0] == $past(device_event[0]))
		else $error("emulation pin zero not driven as output");
	// A test reset pulse shorter than two clocks legally clears the mode again
	chk_bsc_latch: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
		(trst_rise && emu_s == jemc_pkg::BSC_PATTERN) ##1 trst_s |-> bsc_mode_reg [*2])
		else $error("boundary-scan mode not latched");
	chk_wir_entry: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
		$rose(strap_wait_reg == 2'h3) |-> wir_mode_reg == ($past(emu_s) == jemc_pkg::WIR_PATTERN))
		else $error("wait-in-reset strap not honoured");
	chk_wir_hold: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
		(strap_wait_reg == 2'h3) |=> $stable(wir_mode_reg))
		else $error("wait-in-reset mode changed after strap");

endmodule : jemc_top

// ===== bench/jemc_probe.sv
// Purpose: Debug probe model driving the test access port
// Assumes: Test clock idles low between frames, period 160 ns
// Notes: Released inputs return to their pull-up level
`timescale 1ns/100ps
module jemc_probe (
	output logic test_clock,
	output logic test_mode_select,
	output logic test_data_in,
	input wire logic test_data_out
);
	// ==========
	// Clocking
	initial begin
		test_clock = 1'b0;
		test_mode_select = 1'b1;
		test_data_in = 1'b1;
	end

	// Inputs change after the falling edge so they are settled at the rising one
	task automatic tick(input logic m, input logic d, output logic o);
		test_mode_select = m;
		test_data_in = d;
		#80;
		o = test_data_out;
		test_clock = 1'b1;
		#80;
		test_clock = 1'b0;
	endtask : tick

	// ==========
	// Scan from idle through shift and update back to idle
	task automatic xfer(input logic ir, input logic [7:0] din, input int n, output logic [7:0] dout);
		logic o;
		dout = 8'h00;
		tick(1'b1, 1'b1, o);
		if (ir)
			tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o);
		tick(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o);
		test_mode_select = 1'b1;
		test_data_in = 1'b1;
	endtask : xfer
endmodule : jemc_probe

// ===== bench/jemc_top_tb.sv
// Purpose: Self-checking bench for the test-access and emulation pin block
// Assumes: Pins pulled up when nobody drives them
// Notes: Random data from a fixed-seed shift register
`timescale 1ns/100ps
module jemc_top_tb;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic test_reset = 1'b0;
	logic test_clock, test_mode_select, test_data_in, test_data_out, o;
	logic [1:0] emu_pin_in, probe_event;
	logic [1:0] device_event = 2'h0;
	logic [1:0] pdrv_en = 2'h3;
	logic [1:0] pdrv = 2'h2;
	jemc_pkg::jemc_emu_drive_t emu_drive;
	logic scan_control, boundary_scan_mode, wait_in_reset_mode;
	logic [15:0] seed = 16'h1F16;
	logic [7:0] dout, din;
	int bad_count = 0;
	int n_compared = 0;

	always #10 clock = ~clock;
	// ==========
	// Wire level from all drivers
	for (genvar i = 0; i < 2; i++) begin : g_pin
		assign emu_pin_in[i] = !emu_drive.oe_n[i] ? emu_drive.level[i] : (pdrv_en[i] ? pdrv[i] : 1'b1);
	end

	jemc_probe probe (.test_clock(test_clock), .test_mode_select(test_mode_select),
		.test_data_in(test_data_in), .test_data_out(test_data_out));
	jemc_top dut (.clock(clock), .arst_n(arst_n), .test_clock(test_clock), .test_reset(test_reset),
		.test_mode_select(test_mode_select), .test_data_in(test_data_in), .test_data_out(test_data_out),
		.emu_pin_in(emu_pin_in), .emu_drive(emu_drive), .device_event(device_event),
		.probe_event(probe_event), .scan_control(scan_control),
		.boundary_scan_mode(boundary_scan_mode), .wait_in_reset_mode(wait_in_reset_mode));

	// ==========
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Bypass captures 0, so data returns one place late
	function automatic logic [7:0] exp_bypass(input logic [7:0] d);
		return {d[6:0], 1'b0};
	endfunction : exp_bypass
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	// Six clocks covers the two-stage sync plus the output register
	task automatic settle();
		repeat (6) @(posedge clock);
		@(negedge clock);
	endtask : settle
	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	initial begin
		#1000000;
		bad_count++;
		finish_test();
	end

	// ==========
	// Main sequence
	initial begin
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			arst_n <= 1'b0;
			pdrv <= k ? 2'h3 : jemc_pkg::WIR_PATTERN;
			repeat (12) @(posedge clock);
			arst_n <= 1'b1;
			settle();
			check(wait_in_reset_mode, k ? 1'b0 : 1'b1, "wait in reset");
			check(scan_control, 1'b0, "scan control idle");
			check(emu_drive.oe_n, jemc_pkg::OE_N_OFF, "pins released");
			check(probe_event, 2'h0, "no event");
			@(posedge clock);
			pdrv <= k ? jemc_pkg::WIR_PATTERN : 2'h3;
			settle();
			check(wait_in_reset_mode, k ? 1'b0 : 1'b1, "wait in reset held");
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			pdrv_en <= 2'h3;
			pdrv <= k ? 2'h3 : jemc_pkg::BSC_PATTERN;
			repeat (4) @(posedge clock);
			test_reset <= 1'b1;
			settle();
			check(boundary_scan_mode, k ? 1'b0 : 1'b1, "boundary scan");
			check(scan_control, 1'b1, "scan control");
			@(posedge clock);
			pdrv_en <= 2'h0;
			test_reset <= 1'b0;
			settle();
			check(boundary_scan_mode, 1'b0, "mode cleared");
			check(scan_control, 1'b0, "scan released");
		end
		@(posedge clock);
		test_reset <= 1'b1;
		settle();
		probe.tick(1'b0, 1'b1, o);
		probe.xfer(1'b1, {4'h0, jemc_pkg::IR_EMU_DIR}, 4, dout);
		check(dout, 8'h01, "instruction capture");
		probe.xfer(1'b0, 8'h01, 2, dout);
		settle();
		check(emu_drive.oe_n, 2'h2, "pin zero driven");
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			din[1:0] = device_event;
			seed = lfsr(seed);
			device_event <= seed[1:0];
			@(negedge clock);
			check(emu_drive.level, din[1:0], "event to probe");
		end
		@(posedge clock);
		pdrv_en <= 2'h2;
		pdrv <= 2'h0;
		settle();
		check(probe_event, 2'h2, "event from probe");
		probe.xfer(1'b1, 8'h0F, 4, dout);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			din = (i == 0) ? 8'hFF : seed[7:0];
			probe.xfer(1'b0, din, 8, dout);
			check(dout, exp_bypass(din), "bypass shift");
		end
		@(posedge clock);
		test_reset <= 1'b0;
		pdrv_en <= 2'h0;
		settle();
		check(emu_drive.oe_n, 2'h3, "pins off");
		check(test_data_out, 1'b0, "data out cleared");
		check(probe_event, 2'h0, "event off");
		finish_test();
	end
endmodule : jemc_top_tb
